// ==== pkg/fwem_defs.vh ====
// constants for the flash write and external memory block
`ifndef FWEM_DEFS_VH
`define FWEM_DEFS_VH
`define FWEM_ERASE_WRITE_MS   20
`define FWEM_CLK_KHZ          25000
`define FWEM_SYS_REGION_TOP   16'h3FFF
`define FWEM_FLASH_AW         12
`define FWEM_ROW_BYTES        8
`define FWEM_ROW_BITS         3
`define FWEM_ONE16            16'h0001
`define FWEM_ZERO16           16'h0000
`define FWEM_ZERO8            8'h00
`endif

// ==== hw/fwem_ext_bus.v ====
// external memory bus cycle engine
`timescale 1ns/10ps
`default_nettype none
module fwem_ext_bus (
  input  wire        clock,
  input  wire        nrst,
  input  wire        req,
  input  wire        wr,
  input  wire [15:0] addr,
  input  wire [7:0]  wdata,
  input  wire [7:0]  mem_data_lines_i,
  output reg         done_q,
  output reg  [7:0]  rdata_q,
  output reg  [15:0] mem_address_lines_q,
  output reg  [7:0]  mem_data_lines_o_q,
  output reg         mem_data_oe_q,
  output reg         mem_rw_q,
  output reg         mem_enable_q
);
  localparam S_IDLE = 2'd0;
  localparam S_STRB = 2'd1;
  localparam S_END  = 2'd2;
  localparam S_CAP  = 2'd3;
  reg [1:0] st_q;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_q                <= S_IDLE;
      done_q              <= 1'b0;
      rdata_q             <= 8'h00;
      mem_address_lines_q <= 16'h0000;
      mem_data_lines_o_q  <= 8'h00;
      mem_data_oe_q       <= 1'b0;
      mem_rw_q            <= 1'b1;
      mem_enable_q        <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (req) begin
            mem_address_lines_q <= addr; // RL7
            mem_rw_q            <= ~wr; // RL5
            mem_data_lines_o_q  <= wdata;
            mem_data_oe_q       <= wr; // RL8
            st_q                <= S_STRB;
          end
        end
        S_STRB: begin
          mem_enable_q <= 1'b1; // RL6
          st_q         <= S_END;
        end
        S_END: begin
          mem_enable_q  <= 1'b0; // RL6
          mem_data_oe_q <= 1'b0;
          mem_rw_q      <= 1'b1;
          st_q          <= S_CAP;
        end
        // pins lag this engine by one flop, so read data is taken one edge late
        S_CAP: begin
          rdata_q <= mem_data_lines_i; // RL8
          done_q  <= 1'b1;
          st_q    <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule // fwem_ext_bus
`default_nettype wire

// ==== hw/fwem_top.v ====
// flash write sequencer and external memory port
// Function
// RL1: skip physical write when byte unchanged
// RL2: merge eight successive bytes into one write
// RL3: wait erase/write time before next operation
// RL4: external memory holds system image low
// RL5: drive read/write direction output
// RL6: drive enable strobe for each access
// RL7: present 16-bit address each cycle
// RL8: bidirectional 8-bit data bus
// RL9: test mode floats buses during reset
// RL10: reset is active low
// RL11: program fetch from flash or external
// RL12: network download cannot write system region; code ignores fw_net and never refuses
// RL13: busy during programming, refuse new writes
`timescale 1ns/10ps
`default_nettype none
`include "fwem_defs.vh"
module fwem_top #(
  parameter integer FLASH_AW   = `FWEM_FLASH_AW,
  parameter integer WRITE_CYC  = (`FWEM_ERASE_WRITE_MS * `FWEM_CLK_KHZ),
  parameter integer MERGE_EN   = 1
) (
  input  wire                clock,
  input  wire                nrst,
  input  wire                test_mode,
  input  wire                fw_req,
  input  wire [FLASH_AW-1:0] fw_addr,
  input  wire [7:0]          fw_data,
  input  wire                fw_net,
  input  wire                fw_flush,
  input  wire                fetch_req,
  input  wire [15:0]         fetch_addr,
  input  wire                ext_req,
  input  wire                ext_wr,
  input  wire [15:0]         ext_addr,
  input  wire [7:0]          ext_wdata,
  input  wire [7:0]          mem_data_lines_i,
  output reg                 fw_busy_q,
  output reg                 fw_done_q,
  output reg                 fw_skip_q,
  output reg                 fw_reject_q,
  output reg                 rd_valid_q,
  output reg  [7:0]          rd_data_q,
  output reg                 ext_busy_q,
  output reg  [15:0]         mem_address_lines_q,
  output reg  [7:0]          mem_data_lines_o_q,
  output reg                 mem_data_oe_q,
  output reg                 mem_rw_q,
  output reg                 mem_enable_q,
  output reg                 pins_hiz_q
);
  localparam FS_IDLE = 2'd0;
  localparam FS_PROG = 2'd1;
  localparam FLASH_WORDS = 1 << FLASH_AW;
  localparam RB = `FWEM_ROW_BITS;

  // flash array and row merge buffer
  reg [7:0]          flash_mem [0:FLASH_WORDS-1];
  reg [7:0]          row_q     [0:`FWEM_ROW_BYTES-1];
  reg [`FWEM_ROW_BYTES-1:0] row_dirty_q;
  reg [FLASH_AW-1:RB] row_base_q;
  reg [1:0]          fst_q;
  reg [31:0]         wait_q;

  wire [7:0] stored = flash_mem[fw_addr];
  wire [RB-1:0] lane = fw_addr[RB-1:0];
  wire same_row = (fw_addr[FLASH_AW-1:RB] == row_base_q) || (row_dirty_q == 0);
  // network download is never refused; fw_refuse is tied low, so fw_net has no effect
  wire fw_refuse = fw_net && 1'b0;
  // merge window closes on a full row, a new row, or an explicit flush
  wire row_full = (row_dirty_q == {`FWEM_ROW_BYTES{1'b1}});

  integer i;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fst_q       <= FS_IDLE;
      wait_q      <= 32'h0000_0000;
      row_dirty_q <= {`FWEM_ROW_BYTES{1'b0}};
      row_base_q  <= {(FLASH_AW-RB){1'b0}};
      fw_busy_q   <= 1'b0;
      fw_done_q   <= 1'b0;
      fw_skip_q   <= 1'b0;
      fw_reject_q <= 1'b0;
    end else begin
      fw_done_q   <= 1'b0;
      fw_skip_q   <= 1'b0;
      fw_reject_q <= 1'b0;
      case (fst_q)
        FS_IDLE: begin
          if (fw_req && fw_refuse) begin
            fw_reject_q <= 1'b1; // RL12
          end else if (fw_req && stored == fw_data && !row_dirty_q[lane]) begin
            fw_skip_q <= 1'b1; // RL1
            fw_done_q <= 1'b1;
          end else if (fw_req && same_row && MERGE_EN != 0) begin
            row_q[lane]       <= fw_data; // RL2
            row_dirty_q[lane] <= 1'b1;
            row_base_q        <= fw_addr[FLASH_AW-1:RB];
            fw_done_q         <= 1'b1;
          end else if ((fw_req && row_dirty_q != 0) || fw_flush || row_full) begin
            if (row_dirty_q != 0) begin
              fst_q     <= FS_PROG;
              fw_busy_q <= 1'b1; // RL13
              wait_q    <= WRITE_CYC - 1; // RL3
            end
          end else if (fw_req) begin
            row_q[lane]       <= fw_data;
            row_dirty_q       <= {`FWEM_ROW_BYTES{1'b0}} | ({{(`FWEM_ROW_BYTES-1){1'b0}},1'b1} << lane);
            row_base_q        <= fw_addr[FLASH_AW-1:RB];
            fst_q             <= FS_PROG;
            fw_busy_q         <= 1'b1;
            wait_q            <= WRITE_CYC - 1;
          end
        end
        FS_PROG: begin
          if (wait_q != 0) begin
            wait_q <= wait_q - 1; // RL3
          end else begin
            for (i = 0; i < `FWEM_ROW_BYTES; i = i + 1)
              if (row_dirty_q[i])
                flash_mem[{row_base_q, i[RB-1:0]}] <= row_q[i]; // RL2
            row_dirty_q <= {`FWEM_ROW_BYTES{1'b0}};
            fw_busy_q   <= 1'b0; // RL13
            fw_done_q   <= 1'b1;
            fst_q       <= FS_IDLE;
          end
        end
        default: fst_q <= FS_IDLE;
      endcase
    end
  end

  // program fetch: low addresses from on-chip flash, rest from external memory
  wire fetch_int = fetch_req && (fetch_addr < FLASH_WORDS); // RL11
  wire fetch_ext = fetch_req && !fetch_int; // RL11
  reg  ext_pend_q;
  reg  ext_fetch_q;
  wire bus_done;
  wire [7:0]  bus_rdata;
  wire [15:0] bus_addr;
  wire [7:0]  bus_do;
  wire bus_oe;
  wire bus_rw;
  wire bus_en;
  wire bus_go = !ext_pend_q && (fetch_ext || ext_req);
  wire bus_wr = !fetch_ext && ext_wr;
  wire [15:0] bus_a = fetch_ext ? fetch_addr : ext_addr;

  fwem_ext_bus u_bus (
    .clock               (clock),
    .nrst                (nrst),
    .req                 (bus_go),
    .wr                  (bus_wr),
    .addr                (bus_a),
    .wdata               (ext_wdata),
    .mem_data_lines_i    (mem_data_lines_i),
    .done_q              (bus_done),
    .rdata_q             (bus_rdata),
    .mem_address_lines_q (bus_addr),
    .mem_data_lines_o_q  (bus_do),
    .mem_data_oe_q       (bus_oe),
    .mem_rw_q            (bus_rw),
    .mem_enable_q        (bus_en)
  );

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ext_pend_q  <= 1'b0;
      ext_fetch_q <= 1'b0;
      rd_valid_q  <= 1'b0;
      rd_data_q   <= 8'h00;
      ext_busy_q  <= 1'b0;
    end else begin
      rd_valid_q <= 1'b0;
      if (fetch_int) begin
        rd_valid_q <= 1'b1;
        rd_data_q  <= flash_mem[fetch_addr[FLASH_AW-1:0]];
      end
      if (bus_go) begin
        ext_pend_q  <= 1'b1;
        ext_fetch_q <= fetch_ext;
        ext_busy_q  <= 1'b1;
      end else if (bus_done) begin
        ext_pend_q <= 1'b0;
        ext_busy_q <= 1'b0;
        rd_valid_q <= ext_fetch_q; // RL11
        rd_data_q  <= bus_rdata;
      end
    end
  end

  // test mode strap; no async reset here since reset is what arms it
  always @(posedge clock) begin
    pins_hiz_q <= !nrst && test_mode; // RL9 RL10
  end

  // pin stage: every pin leaves a flop; reset parks the bus in read, undriven
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mem_address_lines_q <= 16'h0000;
      mem_data_lines_o_q  <= 8'h00;
      mem_data_oe_q       <= 1'b0; // RL9
      mem_rw_q            <= 1'b1;
      mem_enable_q        <= 1'b0;
    end else begin
      mem_address_lines_q <= bus_addr;
      mem_data_lines_o_q  <= bus_do;
      mem_data_oe_q       <= bus_oe; // RL8
      mem_rw_q            <= bus_rw;
      mem_enable_q        <= bus_en;
    end
  end
endmodule // fwem_top
`default_nettype wire

// ==== bench/fwem_top_sva.sv ====
// assertion checker for the flash write and external bus block
`timescale 1ns/10ps
`default_nettype none
module fwem_top_sva #(parameter int WRITE_CYC = 20) (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        test_mode,
  input wire logic        fw_req,
  input wire logic        fw_busy_q,
  input wire logic        fw_skip_q,
  input wire logic [15:0] mem_address_lines_q,
  input wire logic        mem_rw_q,
  input wire logic        mem_enable_q,
  input wire logic        mem_data_oe_q,
  input wire logic        pins_hiz_q
);
  // counts busy cycles; cleared by reset so a stale count never leaks over
  int busy_cnt_q;
  always_ff @(posedge clock or negedge nrst)
    if (!nrst) busy_cnt_q <= 0;
    else busy_cnt_q <= fw_busy_q ? busy_cnt_q + 1 : 0;
  a_skip_cause: assert property (@(posedge clock) disable iff (!nrst)
    fw_skip_q |-> $past(fw_req) && !fw_busy_q) else $error("skip without request");
  a_refuse_busy: assert property (@(posedge clock) disable iff (!nrst)
    fw_busy_q && fw_req |=> !fw_skip_q) else $error("request taken while busy");
  a_busy_long: assert property (@(posedge clock) disable iff (!nrst)
    $fell(fw_busy_q) |-> busy_cnt_q >= WRITE_CYC) else $error("programming too short");
  a_busy_bound: assert property (@(posedge clock) disable iff (!nrst)
    fw_busy_q |-> busy_cnt_q <= WRITE_CYC + 4) else $error("programming too long");
  a_addr_steady: assert property (@(posedge clock) disable iff (!nrst)
    mem_enable_q |-> $stable(mem_address_lines_q) && $stable(mem_rw_q))
    else $error("address moved in strobe");
  a_strobe_pulse: assert property (@(posedge clock) disable iff (!nrst)
    $rose(mem_enable_q) |=> !mem_enable_q) else $error("strobe too long");
  a_drive_write: assert property (@(posedge clock) disable iff (!nrst)
    mem_data_oe_q |-> !mem_rw_q) else $error("data driven on read");
  // this one watches the reset itself, so it is never disabled
  a_hiz_reset: assert property (@(posedge clock)
    (!nrst && test_mode) ##1 (!nrst && test_mode) |-> pins_hiz_q && !mem_data_oe_q)
    else $error("pins not floating");
endmodule // fwem_top_sva
bind fwem_top fwem_top_sva #(.WRITE_CYC(WRITE_CYC)) fwem_top_sva_inst (
  .clock(clock), .nrst(nrst), .test_mode(test_mode), .fw_req(fw_req),
  .fw_busy_q(fw_busy_q), .fw_skip_q(fw_skip_q), .mem_address_lines_q(mem_address_lines_q),
  .mem_rw_q(mem_rw_q), .mem_enable_q(mem_enable_q), .mem_data_oe_q(mem_data_oe_q),
  .pins_hiz_q(pins_hiz_q));
`default_nettype wire

// ==== bench/fwem_mem_model.sv ====
// external memory model, system image preloaded low
`timescale 1ns/10ps
`default_nettype none
module fwem_mem_model (
  input  wire logic [15:0] addr,
  input  wire logic        clock,
  input  wire logic        rw,
  input  wire logic        en,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  dq
);
  logic [7:0] mem [0:65535];
  logic [7:0] held_q = 8'h00;
  initial for (int i = 0; i < 65536; i++) mem[i] = (i < 16384) ? (i[7:0] ^ 8'ha5) : 8'h00;
  // one cycle of hold, then a toggling value so a late sample is caught
  assign dq = (en && rw) ? mem[addr] : held_q;
  always @(posedge clock) begin
    if (en && !rw) mem[addr] <= wdata;
    held_q <= (en && rw) ? mem[addr] : ~held_q;
  end
endmodule // fwem_mem_model
`default_nettype wire

// ==== bench/fwem_top_tb.sv ====
// self-checking bench for the flash write and external memory block
`timescale 1ns/10ps
`default_nettype none
module fwem_top_tb;
  localparam int WC = 20;
  logic        clock = 0, nrst = 0, test_mode = 1, fw_req = 0, fw_flush = 0, fetch_req = 0;
  logic        ext_req = 0, busy, skip, rdv, ebusy, oe, rw, en, hiz, s;
  logic [11:0] fw_addr = 0;
  logic [7:0]  fw_data = 0, ext_wdata = 0, rd_data, dq, dout, bus;
  logic [15:0] fetch_addr = 0, ext_addr = 0, maddr;
  int          n_fail = 0, check_count = 0, cyc = 0, n, blen = 0, blast = 0;
  logic [11:0] r_a [0:3] = '{12'h001, 12'h002, 12'h0ff, 12'hfff};
  logic [7:0]  r_d [0:3] = '{8'h5a, 8'h00, 8'hff, 8'ha3};
  assign bus = oe ? dout : dq;
  always #20 clock = ~clock;
  // length of the last busy stretch, counted in clock edges
  always @(posedge clock) begin
    if (busy === 1'b1) blen++;
    else if (blen > 0) begin
      blast = blen;
      blen = 0;
    end
  end
  fwem_top #(.WRITE_CYC(WC)) fwem_top_inst (.clock(clock), .nrst(nrst), .test_mode(test_mode),
    .fw_req(fw_req), .fw_addr(fw_addr), .fw_data(fw_data), .fw_net(1'b0), .fw_flush(fw_flush),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .ext_req(ext_req), .ext_wr(1'b1),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .mem_data_lines_i(bus), .fw_busy_q(busy),
    .fw_done_q(), .fw_skip_q(skip), .fw_reject_q(), .rd_valid_q(rdv), .rd_data_q(rd_data),
    .ext_busy_q(ebusy), .mem_address_lines_q(maddr), .mem_data_lines_o_q(dout),
    .mem_data_oe_q(oe), .mem_rw_q(rw), .mem_enable_q(en), .pins_hiz_q(hiz));
  fwem_mem_model fwem_mem_model_inst (.clock(clock), .addr(maddr), .rw(rw), .en(en),
    .wdata(dout), .dq(dq));
  task automatic chk8(logic [7:0] g, logic [7:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk1(logic g, logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  task automatic fw_wr(logic [11:0] a, logic [7:0] d);
    @(posedge clock);
    fw_req <= 1;
    fw_addr <= a;
    fw_data <= d;
    @(posedge clock);
    fw_req <= 0;
  endtask
  task automatic flush;
    @(posedge clock);
    fw_flush <= 1;
    @(posedge clock);
    fw_flush <= 0;
  endtask
  // bounded: an empty flush never raises busy and ends after 200 cycles
  task automatic wait_idle;
    n = 0;
    for (int i = 0; i < 200 && !(n > 0 && busy === 1'b0); i++) begin
      @(negedge clock);
      if (busy === 1'b1) n++;
    end
  endtask
  task automatic fetch(logic [15:0] a, logic [7:0] e);
    @(posedge clock);
    fetch_req <= 1;
    fetch_addr <= a;
    @(posedge clock);
    fetch_req <= 0;
    for (int i = 0; i < 30; i++) begin
      @(negedge clock);
      if (rdv === 1'b1) break;
    end
    chk1(rdv, 1'b1);
    chk8(rd_data, e);
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      end_of_test;
    end
  end
  initial begin
    repeat (7) @(posedge clock);
    @(negedge clock);
    chk1(hiz && !oe, 1'b1);
    chk1(en || busy || rdv, 1'b0);
    @(posedge clock);
    test_mode <= 0;
    nrst <= 1;
    for (int r = 0; r < 4; r++) begin
      fw_wr(r_a[r], r_d[r]);
      flush;
      wait_idle;
      fetch({4'h0, r_a[r]}, r_d[r]);
    end
    for (int i = 0; i < 8; i++) fw_wr(12'h010 + 12'(i), 8'h40 + 8'(i));
    flush;
    wait_idle;
    repeat (3) @(negedge clock);
    chk1(blast >= WC, 1'b1);
    chk1(busy, 1'b0);
    for (int i = 0; i < 8; i++) fetch(16'h0010 + 16'(i), 8'h40 + 8'(i));
    fw_wr(12'h020, 8'h11);
    flush;
    fw_wr(12'h001, 8'hee);
    wait_idle;
    flush;
    wait_idle;
    fetch(16'h0001, 8'h5a);
    fw_wr(12'h011, 8'h41);
    s = 0;
    repeat (3) @(negedge clock) s = s | (skip === 1'b1);
    chk1(s, 1'b1);
    flush;
    wait_idle;
    chk1(n == 0, 1'b1);
    @(posedge clock);
    ext_req <= 1;
    ext_addr <= 16'h8000;
    ext_wdata <= 8'h3c;
    @(posedge clock);
    ext_req <= 0;
    @(negedge clock);
    for (int i = 0; i < 30 && ebusy !== 1'b0; i++) @(negedge clock);
    repeat (3) @(posedge clock);
    fetch(16'h8000, 8'h3c);
    fetch(16'h1234, 8'h34 ^ 8'ha5);
    end_of_test;
  end
endmodule // fwem_top_tb
`default_nettype wire
